// [tb/capture_compare_timer_tb.sv]
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module capture_compare_timer_tb
	import cct_pkg::*;
;
	typedef struct {string nm; logic [31:0] v; logic e;} cct_note_t;
	logic          pclk;
	logic          presetn;
	logic          time_base_divider;
	logic          strobe = 1'h0;
	cct_apb_req_t  req;
	cct_apb_rsp_t  rsp;
	logic [1:0]    src;
	logic [1:0]    pin;
	logic [1:0]    pout;
	logic [1:0]    poe;
	logic [2:0]    act;
	logic [5:0]    lvl;
	logic [47:0]   vec;
	logic [2:0]    en;
	logic [2:0]    p0;
	logic [2:0]    p1;
	logic [1:0]    md[4];
	logic [15:0]   ex[4];
	int            failures;
	int            checked;
	int            cyc = 0;
	cct_note_t     notes[$];
	cct_note_t     n;
	////////////////////////////////////////////////////////////////////////////
	cct_timer #(.NCH(2)) cct_timer_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.time_base_clock(time_base_divider), .instruction_start_strobe(strobe), .timer_channel_pin_in(pin),
		.timer_channel_pin_out(pout), .timer_channel_pin_oe(poe), .irq_active(act), .irq_level(lvl),
		.irq_vector(vec));
	cct_pin_partner cct_pin_partner_inst (.src_level(src), .dev_oe(poe), .dev_out(pout), .pin_level(pin));
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// APB transfer; a read notes its expected data for the monitor
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, string nm = "", logic e = 1'h0);
		if (!w)
			notes.push_back('{nm, d, e});
		@(posedge pclk);
		req <= '{1'h1, 1'h0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'h1;
		do @(posedge pclk); while (rsp.pready !== 1'h1);
		req.psel    <= 1'h0;
		req.penable <= 1'h0;
	endtask : xfer
	////////////////////////////////////////////////////////////////////////////
	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc    <= cyc + 1;
		strobe <= (cyc % 4 == 0);
		if (cyc > 20000) begin
			failures++;
			print_verdict();
		end
	end

	// Read monitor: oldest note against the completed access
	always @(posedge pclk) begin
		if (req.psel && req.penable && rsp.pready === 1'h1 && !req.pwrite) begin
			n = notes.pop_front();
			check(n.nm, rsp.prdata, n.v);
			check("slverr", 32'(rsp.pslverr), 32'(n.e));
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 0; presetn = 0; time_base_divider = 1; src = 0; req = '0; failures = 0; checked = 0;
		md = '{2'h0, 2'h1, 2'h2, 2'h3};
		ex = '{16'h0040, 16'h1002, 16'h1005, 16'h1005};
		void'($urandom(69702));
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		// Reset values and unmapped access
		check("oe_rst", 32'(poe), 32'h3);
		xfer(0, OFS_COUNTER, 32'h0, "cnt");
		xfer(0, OFS_CTRL, 32'(CTL_RESET), "ctl");
		xfer(0, OFS_EDGE, 32'(EDGE_FIXED1), "edge");
		xfer(0, OFS_CHCTL, 32'(CH_FIXED1), "ch0");
		xfer(0, 8'h40, 32'h0, "unmapped", 1'h1);
		// Overflow with compare off
		xfer(1, OFS_CTRL, 32'h38);
		xfer(1, OFS_COUNTER, 32'hFFFE);
		repeat (4) @(posedge pclk);
		xfer(0, OFS_IRQ_REQ, 32'h1, "req_ovf");
		// Enable and priority gating
		en = 3'($urandom); p0 = 3'($urandom); p1 = 3'($urandom);
		xfer(1, OFS_IRQ_EN, 32'(en));
		xfer(1, OFS_IRQ_PRI0, 32'(p0));
		xfer(1, OFS_IRQ_PRI1, 32'(p1));
		xfer(0, OFS_IRQ_PRI0, 32'(p0), "pri0");
		@(negedge pclk);
		check("active", 32'(act), 32'(en & 3'h1));
		check("level", 32'(lvl), 32'({p1[2], p0[2], p1[1], p0[1], p1[0], p0[0]}));
		check("vec_lo", vec[31:0], {VEC_CH0, VEC_OVF});
		check("vec_hi", 32'(vec[47:32]), 32'(VEC_CH1));
		// Compare match on both channels
		xfer(1, OFS_CTRL, 32'h0);
		xfer(1, OFS_IRQ_REQ, 32'h0);
		xfer(1, OFS_COUNTER, 32'h000E);
		xfer(1, OFS_VALUE, 32'h0010);
		xfer(1, OFS_BUFFER, 32'h0040);
		xfer(1, OFS_CHCTL, 32'h2);
		xfer(1, OFS_VALUE + OFS_CH_STEP, 32'h0012);
		xfer(1, OFS_BUFFER + OFS_CH_STEP, 32'h0050);
		xfer(1, OFS_CHCTL + OFS_CH_STEP, 32'h6);
		@(negedge pclk);
		check("pin1_init", 32'(pin[1]), 32'h0);
		xfer(1, OFS_CTRL, 32'h08);
		repeat (10) @(posedge pclk);
		xfer(1, OFS_CTRL, 32'h0);
		@(negedge pclk);
		check("pin0", 32'(pin[0]), 32'h1);
		check("pin1", 32'(pin[1]), 32'h1);
		xfer(0, OFS_CHCTL, 32'hF9, "ch0_lvl");
		xfer(0, OFS_VALUE, 32'h0040, "ch0_val");
		xfer(0, OFS_CHCTL + OFS_CH_STEP, 32'hFF, "ch1_lvl");
		xfer(0, OFS_VALUE + OFS_CH_STEP, 32'h0050, "ch1_val");
		xfer(0, OFS_IRQ_REQ, 32'h6, "req_cmp");
		// Capture on channel 0, one pass per edge selection
		xfer(1, OFS_IRQ_REQ, 32'h0);
		xfer(1, OFS_CTRL, 32'h18);
		for (int i = 0; i < 4; i++) begin
			xfer(1, OFS_EDGE, 32'(md[i]) << 2);
			xfer(1, OFS_COUNTER, 32'h1000);
			repeat (2) @(posedge pclk);
			src[0] <= 1'h1;
			repeat (3) @(posedge pclk);
			src[0] <= 1'h0;
			repeat (2) @(posedge pclk);
			xfer(0, OFS_VALUE, 32'(ex[i]), "cap_val");
		end
		check("oe_cap", 32'(poe), 32'h2);
		xfer(0, OFS_IRQ_REQ, 32'h2, "req_cap");
		// Count pulses from the time-base divider
		time_base_divider <= 1'h0;
		xfer(1, OFS_COUNTER, 32'h2000);
		repeat (3) begin
			time_base_divider <= 1'h1;
			@(posedge pclk);
			time_base_divider <= 1'h0;
			@(posedge pclk);
		end
		xfer(0, OFS_COUNTER, 32'h2003, "cnt_div");
		print_verdict();
	end
endmodule : capture_compare_timer_tb

// [tb/cct_pin_partner.sv]
// Pulse source and load model on the timer channel pins
`timescale 1ns/1ps
module cct_pin_partner
	import cct_pkg::*;
(
	input  wire logic [1:0] src_level,
	input  wire logic [1:0] dev_oe,
	input  wire logic [1:0] dev_out,
	output logic      [1:0] pin_level
);
	////////////////////////////////////////////////////////////////////////////
	// Wire level: device drives when enabled, else the source
	// Source levels move only at clock edges; the bench holds each pulse three periods
	assign pin_level = (dev_oe & dev_out) | (~dev_oe & src_level);
endmodule : cct_pin_partner

// [verilog/cct_pkg.sv]
// Package for the two-channel capture/compare timer
package cct_pkg;
	localparam int          CCT_NCH      = 2;
	localparam int          CCT_CW       = 16;
	localparam int          CCT_AW       = 8;
	// Register byte offsets
	localparam logic [7:0]  OFS_COUNTER  = 8'h00;
	localparam logic [7:0]  OFS_CTRL     = 8'h04;
	localparam logic [7:0]  OFS_EDGE     = 8'h08;
	localparam logic [7:0]  OFS_CHCTL    = 8'h0C;
	localparam logic [7:0]  OFS_VALUE    = 8'h14;
	localparam logic [7:0]  OFS_BUFFER   = 8'h1C;
	localparam logic [7:0]  OFS_IRQ_REQ  = 8'h24;
	localparam logic [7:0]  OFS_IRQ_EN   = 8'h28;
	localparam logic [7:0]  OFS_IRQ_PRI0 = 8'h2C;
	localparam logic [7:0]  OFS_IRQ_PRI1 = 8'h30;
	localparam logic [7:0]  OFS_CH_STEP  = 8'h04;
	// Counter control fields
	localparam int          CTL_CLKSEL_W = 3;
	localparam int          CTL_RUN_BIT  = 3;
	localparam int          CTL_MODE_LSB = 4;
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	// Capture edge control fields
	localparam int          EDGE_LSB     = 2;
	localparam int          EDGE_W       = 2;
	localparam logic [7:0]  EDGE_FIXED1  = 8'hC0;
	localparam logic [3:0]  EDGE_RESET   = 4'h0;
	// Channel control fields
	localparam int          CH_OUT_BIT   = 0;
	localparam int          CH_NEXT_BIT  = 1;
	localparam int          CH_FOLL_BIT  = 2;
	localparam logic [7:0]  CH_FIXED1    = 8'hF8;
	localparam logic [2:0]  CH_RESET     = 3'h0;
	// Interrupt factor positions
	localparam int          IRQ_N        = 3;
	localparam int          IRQ_OVF      = 0;
	localparam int          IRQ_CH0      = 1;
	localparam logic [15:0] VEC_OVF      = 16'h000C;
	localparam logic [15:0] VEC_CH0      = 16'h0016;
	localparam logic [15:0] VEC_CH1      = 16'h0018;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;

	typedef enum logic [1:0] {
		EDGE_NONE,
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} cct_edge_t;

	typedef struct packed {
		logic                psel;
		logic                penable;
		logic                pwrite;
		logic [CCT_AW-1:0]   paddr;
		logic [31:0]         pwdata;
	} cct_apb_req_t;

	typedef struct packed {
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
	} cct_apb_rsp_t;
endpackage : cct_pkg

// [verilog/cct_timer.sv]
// Two-channel capture/compare timer with APB register access
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Valid edge while running captures counter, requests
// - Capture pins sampled on clock falling edge
// - Compare mode compares value against counter continuously
// - Match requests and copies next level out
// - Match shifts following level, reloads compare value
// - Match signal rises one count after equality
// - Output changes when match meets count pulse
// - Undivided count clock: output changes at compare+1
// - Compare request set at next instruction strobe
// - Count pulse comes from time-base divider
// - Each factor sets its request flag
// - Each factor gated by its enable flag
// - Two priority flags per factor, four levels
// - Overflow and both channels use separate vectors
// - Two edge-select bits per channel, reset invalid
// - Control bits select mode and run counter
// - Following-level bit at bit two
////////////////////////////////////////////////////////////////////////////////
module cct_timer
	import cct_pkg::*;
#(
	parameter int NCH = CCT_NCH
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire cct_apb_req_t       apb_req,
	output cct_apb_rsp_t            apb_rsp,
	input  wire logic               time_base_clock,
	input  wire logic               instruction_start_strobe,
	input  wire logic [NCH-1:0]     timer_channel_pin_in,
	output logic      [NCH-1:0]     timer_channel_pin_out,
	output logic      [NCH-1:0]     timer_channel_pin_oe,
	output logic      [IRQ_N-1:0]   irq_active,
	output logic      [2*IRQ_N-1:0] irq_level,
	output logic      [16*IRQ_N-1:0] irq_vector
);
	////////////////////////////////////////////////////////////////////////////
	// Register bus decode
	function automatic logic hit(input logic [CCT_AW-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
		case (sel)
			EDGE_RISE: edge_hit = cur & ~prv;
			EDGE_FALL: edge_hit = ~cur & prv;
			EDGE_BOTH: edge_hit = cur ^ prv;
			default:   edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	logic [CCT_CW-1:0]  free_running_counter_reg;
	logic [CCT_CW-1:0]  free_running_counter_next;
	logic [7:0]         counter_control_reg;
	logic [3:0]         capture_edge_control_reg;
	logic [IRQ_N-1:0]   irq_request_reg0;
	logic [IRQ_N-1:0]   irq_enable_reg0;
	logic [IRQ_N-1:0]   irq_priority_reg0;
	logic [IRQ_N-1:0]   irq_priority_reg1;
	logic [2:0]         chctl_reg    [NCH];
	logic [CCT_CW-1:0]  value_reg    [NCH];
	logic [CCT_CW-1:0]  buffer_reg   [NCH];
	logic [NCH-1:0]     match_reg;
	logic [NCH-1:0]     cmp_pend_reg;
	logic [NCH-1:0]     pin_neg_reg;
	logic [NCH-1:0]     pin_prev_reg;
	logic [NCH-1:0]     capture_ev;
	logic [NCH-1:0]     fire_ev;
	logic [NCH-1:0]     wr_chctl;
	logic [NCH-1:0]     wr_value;
	logic [NCH-1:0]     wr_buffer;
	logic [IRQ_N-1:0]   irq_set;
	logic [IRQ_N-1:0]   irq_request_next;
	logic [31:0]        rdata;
	logic               mapped;

	wire                wr_en       = apb_req.psel & apb_req.penable & apb_req.pwrite;
	wire                wr_counter  = wr_en & hit(apb_req.paddr, OFS_COUNTER);
	wire                wr_ctrl     = wr_en & hit(apb_req.paddr, OFS_CTRL);
	wire                wr_edge     = wr_en & hit(apb_req.paddr, OFS_EDGE);
	wire                wr_req      = wr_en & hit(apb_req.paddr, OFS_IRQ_REQ);
	wire                wr_ien      = wr_en & hit(apb_req.paddr, OFS_IRQ_EN);
	wire                wr_pri0     = wr_en & hit(apb_req.paddr, OFS_IRQ_PRI0);
	wire                wr_pri1     = wr_en & hit(apb_req.paddr, OFS_IRQ_PRI1);
	wire                run         = counter_control_reg[CTL_RUN_BIT];
	wire                tick        = run & time_base_clock;
	wire                wrap        = tick & (free_running_counter_reg == CNT_MAX);

	assign free_running_counter_next = wr_counter ? apb_req.pwdata[CCT_CW-1:0]
		: (tick ? free_running_counter_reg + CCT_CW'(1) : free_running_counter_reg);

	////////////////////////////////////////////////////////////////////////////
	// Counter, control and interrupt flag registers
	assign irq_set[IRQ_OVF] = wrap;
	assign irq_request_next = (wr_req ? apb_req.pwdata[IRQ_N-1:0] : irq_request_reg0) | irq_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			free_running_counter_reg <= CNT_ZERO;
			counter_control_reg      <= CTL_RESET;
			capture_edge_control_reg <= EDGE_RESET;
			irq_request_reg0         <= '0;
			irq_enable_reg0          <= '0;
			irq_priority_reg0        <= '0;
			irq_priority_reg1        <= '0;
		end else begin
			free_running_counter_reg <= free_running_counter_next;
			irq_request_reg0         <= irq_request_next;
			if (wr_ctrl) counter_control_reg <= {2'b00, apb_req.pwdata[5:0]};
			if (wr_edge) capture_edge_control_reg <= apb_req.pwdata[EDGE_LSB+:4];
			if (wr_ien)  irq_enable_reg0   <= apb_req.pwdata[IRQ_N-1:0];
			if (wr_pri0) irq_priority_reg0 <= apb_req.pwdata[IRQ_N-1:0];
			if (wr_pri1) irq_priority_reg1 <= apb_req.pwdata[IRQ_N-1:0];
		end
	end

	// Capture pins sampled on the falling clock edge
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_neg_reg <= '0;
		end else begin
			pin_neg_reg <= timer_channel_pin_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_reg <= '0;
		end else begin
			pin_prev_reg <= pin_neg_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel capture and compare logic
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			localparam logic [7:0] STEP = 8'(OFS_CH_STEP * gi);
			wire cap_mode = counter_control_reg[CTL_MODE_LSB+gi];
			wire eq       = free_running_counter_reg == value_reg[gi];

			assign wr_chctl[gi]  = wr_en & hit(apb_req.paddr, OFS_CHCTL + STEP);
			assign wr_value[gi]  = wr_en & hit(apb_req.paddr, OFS_VALUE + STEP);
			assign wr_buffer[gi] = wr_en & hit(apb_req.paddr, OFS_BUFFER + STEP);
			assign capture_ev[gi] = run & cap_mode
				& edge_hit(capture_edge_control_reg[EDGE_W*gi+:EDGE_W], pin_neg_reg[gi], pin_prev_reg[gi]);
			assign fire_ev[gi] = ~cap_mode & tick & match_reg[gi];
			assign irq_set[IRQ_CH0+gi] = capture_ev[gi] | (cmp_pend_reg[gi] & instruction_start_strobe);
			assign timer_channel_pin_out[gi] = chctl_reg[gi][CH_OUT_BIT];
			assign timer_channel_pin_oe[gi]  = ~cap_mode;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chctl_reg[gi]    <= CH_RESET;
					value_reg[gi]    <= CNT_ZERO;
					buffer_reg[gi]   <= CNT_ZERO;
					match_reg[gi]    <= 1'b0;
					cmp_pend_reg[gi] <= 1'b0;
				end else begin
					if (tick) match_reg[gi] <= ~cap_mode & eq;
					if (wr_buffer[gi]) buffer_reg[gi] <= apb_req.pwdata[CCT_CW-1:0];
					if (capture_ev[gi]) begin
						value_reg[gi] <= free_running_counter_reg;
					end else if (fire_ev[gi]) begin
						value_reg[gi] <= buffer_reg[gi];
					end else if (wr_value[gi]) begin
						value_reg[gi] <= apb_req.pwdata[CCT_CW-1:0];
					end
					if (fire_ev[gi]) begin
						chctl_reg[gi][CH_OUT_BIT]  <= chctl_reg[gi][CH_NEXT_BIT];
						chctl_reg[gi][CH_NEXT_BIT] <= chctl_reg[gi][CH_FOLL_BIT];
					end else if (wr_chctl[gi]) begin
						chctl_reg[gi] <= apb_req.pwdata[2:0];
					end
					if (fire_ev[gi]) begin
						cmp_pend_reg[gi] <= 1'b1;
					end else if (instruction_start_strobe) begin
						cmp_pend_reg[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Interrupt outputs
	assign irq_active = irq_request_reg0 & irq_enable_reg0;
	genvar gq;
	generate
		for (gq = 0; gq < IRQ_N; gq++) begin : g_pri
			assign irq_level[2*gq+:2] = {irq_priority_reg1[gq], irq_priority_reg0[gq]};
		end
	endgenerate
	assign irq_vector = {VEC_CH1, VEC_CH0, VEC_OVF};

	////////////////////////////////////////////////////////////////////////////
	// Read data selection
	always_comb begin
		rdata  = '0;
		mapped = 1'b1;
		case (apb_req.paddr)
			OFS_COUNTER:             rdata = {16'h0000, free_running_counter_reg};
			OFS_CTRL:                rdata = {24'h000000, counter_control_reg};
			OFS_EDGE:                rdata = {24'h000000, EDGE_FIXED1 | {2'b00, capture_edge_control_reg, 2'b00}};
			OFS_CHCTL:               rdata = {24'h000000, CH_FIXED1 | {5'h00, chctl_reg[0]}};
			OFS_CHCTL + OFS_CH_STEP: rdata = {24'h000000, CH_FIXED1 | {5'h00, chctl_reg[1]}};
			OFS_VALUE:               rdata = {16'h0000, value_reg[0]};
			OFS_VALUE + OFS_CH_STEP: rdata = {16'h0000, value_reg[1]};
			OFS_BUFFER:              rdata = {16'h0000, buffer_reg[0]};
			OFS_BUFFER + OFS_CH_STEP: rdata = {16'h0000, buffer_reg[1]};
			OFS_IRQ_REQ:             rdata = {29'h0, irq_request_reg0};
			OFS_IRQ_EN:              rdata = {29'h0, irq_enable_reg0};
			OFS_IRQ_PRI0:            rdata = {29'h0, irq_priority_reg0};
			OFS_IRQ_PRI1:            rdata = {29'h0, irq_priority_reg1};
			default:                 mapped = 1'b0;
		endcase
	end

	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;
	assign apb_rsp.prdata  = (apb_req.psel & ~apb_req.pwrite) ? rdata : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_capture_load;
		capture_ev[0] |=> (value_reg[0] == $past(free_running_counter_reg)) && irq_request_reg0[IRQ_CH0];
	endproperty
	a_capture_load: assert property (p_capture_load) else $error("capture did not load counter");

	property p_fire_level;
		fire_ev[1] |=> timer_channel_pin_out[1] == $past(chctl_reg[1][CH_NEXT_BIT]);
	endproperty
	a_fire_level: assert property (p_fire_level) else $error("output level not advanced");

	property p_fire_reload;
		fire_ev[0] |=> (value_reg[0] == $past(buffer_reg[0]))
			&& (chctl_reg[0][CH_NEXT_BIT] == $past(chctl_reg[0][CH_FOLL_BIT]));
	endproperty
	a_fire_reload: assert property (p_fire_reload) else $error("compare reload failed");

	property p_match_delay;
		(tick && !counter_control_reg[CTL_MODE_LSB] && free_running_counter_reg == value_reg[0])
			|=> match_reg[0];
	endproperty
	a_match_delay: assert property (p_match_delay) else $error("match signal missing");

	property p_strobe_flag;
		(cmp_pend_reg[0] && instruction_start_strobe && !fire_ev[0])
			|=> irq_request_reg0[IRQ_CH0] && !cmp_pend_reg[0];
	endproperty
	a_strobe_flag: assert property (p_strobe_flag) else $error("compare request not set at strobe");

	property p_wrap;
		(wrap && !wr_counter) |=> (free_running_counter_reg == CNT_ZERO) && irq_request_reg0[IRQ_OVF];
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

	property p_halt;
		(!run && !wr_counter) |=> $stable(free_running_counter_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_no_capture_invalid;
		(capture_edge_control_reg[1:0] == EDGE_NONE) |-> !capture_ev[0];
	endproperty
	a_no_capture_invalid: assert property (p_no_capture_invalid) else $error("capture with edge invalid");

	property p_enable_gate;
		!irq_enable_reg0[IRQ_OVF] |-> !irq_active[IRQ_OVF];
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("disabled request active");

	property p_fire_level0;
		fire_ev[0] |=> timer_channel_pin_out[0] == $past(chctl_reg[0][CH_NEXT_BIT]);
	endproperty
	a_fire_level0: assert property (p_fire_level0) else $error("channel 0 output level not advanced");

	property p_fire_reload1;
		fire_ev[1] |=> (value_reg[1] == $past(buffer_reg[1]))
			&& (chctl_reg[1][CH_NEXT_BIT] == $past(chctl_reg[1][CH_FOLL_BIT]));
	endproperty
	a_fire_reload1: assert property (p_fire_reload1) else $error("channel 1 compare reload failed");

	property p_match_delay1;
		(tick && !counter_control_reg[CTL_MODE_LSB+1] && free_running_counter_reg == value_reg[1])
			|=> match_reg[1];
	endproperty
	a_match_delay1: assert property (p_match_delay1) else $error("channel 1 match signal missing");

	property p_fire_point;
		(fire_ev[0] && $past(tick) && !$past(wr_counter) && $stable(value_reg[0]))
			|-> free_running_counter_reg == value_reg[0] + CCT_CW'(1);
	endproperty
	a_fire_point: assert property (p_fire_point) else $error("output change not at compare plus one");

	property p_strobe_flag1;
		(cmp_pend_reg[1] && instruction_start_strobe && !fire_ev[1])
			|=> irq_request_reg0[IRQ_CH0+1] && !cmp_pend_reg[1];
	endproperty
	a_strobe_flag1: assert property (p_strobe_flag1) else $error("channel 1 request not set at strobe");

	property p_ovf_sticky;
		(irq_request_reg0[IRQ_OVF] && !wr_req) |=> irq_request_reg0[IRQ_OVF];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow request lost");

	property p_count;
		(tick && !wr_counter) |=> free_running_counter_reg == $past(free_running_counter_reg) + CCT_CW'(1);
	endproperty
	a_count: assert property (p_count) else $error("counter did not step on count pulse");

	property p_capture_run;
		!run |-> capture_ev == '0;
	endproperty
	a_capture_run: assert property (p_capture_run) else $error("capture while counter halted");

	property p_oe_mode;
		timer_channel_pin_oe == ~counter_control_reg[CTL_MODE_LSB+:NCH];
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("pin drive does not follow mode");

	property p_no_fire_capture;
		counter_control_reg[CTL_MODE_LSB] |-> !fire_ev[0];
	endproperty
	a_no_fire_capture: assert property (p_no_fire_capture) else $error("compare fired in capture mode");

	property p_buffer_hold;
		!wr_buffer[0] |=> $stable(buffer_reg[0]);
	endproperty
	a_buffer_hold: assert property (p_buffer_hold) else $error("compare buffer changed without write");

	c_capture: cover property (capture_ev[0]);
	c_fire:    cover property (fire_ev[0] ##[1:20] irq_request_reg0[IRQ_CH0]);
	c_wrap:    cover property (wrap);
	c_fire1:   cover property (fire_ev[1]);
	c_pulse:   cover property (run && !time_base_clock ##1 tick);
endmodule : cct_timer
